// ===== fwd_queue_params.svh
`ifndef FWD_QUEUE_PARAMS_SVH
`define FWD_QUEUE_PARAMS_SVH

// ****************************************
// Register offsets
// ****************************************
`define OFS_QUEUE_SPLIT      8'h82
`define OFS_UNK_UCAST        8'h83
`define OFS_UNK_MCAST        8'h84

// ****************************************
// Field positions
// ****************************************
`define SPLIT_LSB            6
`define SPLIT_MSB            7
`define FWD_EN_BIT           5
`define MAP_MSB              4
`define DRIVE_LSB            6
`define DRIVE_MSB            7

// ****************************************
// Reset values
// ****************************************
`define RST_SPLIT            2'h2
`define RST_QUEUE_SPLIT_REG  8'h8c
`define RST_DRIVE            2'h1
`define RST_MAP              5'h00
`define RST_UNK_UCAST_REG    8'h00
`define RST_UNK_MCAST_REG    8'h40
`define RO_MASK_QUEUE_SPLIT  8'hc0
`define RO_MASK_UNK_UCAST    8'h3f
`define RO_MASK_UNK_MCAST    8'hff

// ****************************************
// Port map codes (bit 0 ignored)
// ****************************************
`define MAP_DROP             4'h0
`define MAP_PORT1            4'h1
`define MAP_PORT2            4'h2
`define MAP_PORT12           4'h3
`define MAP_ALL              4'hf
`define MAP_RESERVED         5'h01

`endif

// ===== fwd_queue_pkg.sv
package fwd_queue_pkg;

    // Frame classification presented to the forwarding decision
    typedef struct packed {
        logic       valid;      // Lookup result present
        logic       unk_ucast;  // Unknown unicast destination
        logic       unk_mcast;  // Unknown multicast destination
        logic       ip_mcast;   // Multicast is IP (handled elsewhere)
        logic [1:0] prio;       // 2-bit priority result
    } frame_info_s;

    // Decision sent on to the queue manager
    typedef struct packed {
        logic       valid;      // Decision valid
        logic       handled;    // Unknown-destination rule applied
        logic       drop;       // Frame discarded
        logic [3:0] ports;      // Port mask, bit 3 = port 4
        logic       high_q;     // High priority queue selected
    } fwd_result_s;

    typedef enum logic [2:0] {
        ACC_IDLE  = 3'b001,
        ACC_WRITE = 3'b010,
        ACC_READ  = 3'b100
    } acc_state_e;

endpackage

// ===== fwd_ctrl_regs.sv
`timescale 1ns/10ps
`include "fwd_queue_params.svh"

// Three byte-wide control registers with registered read data
module fwd_ctrl_regs
    import fwd_queue_pkg::*;
(
    input  wire logic       ref_clk,   // Core clock
    input  wire logic       rst_n,     // Async reset, active low
    input  wire logic       wr_en,     // Write strobe
    input  wire logic       rd_en,     // Read strobe
    input  wire logic [7:0] addr,      // Register offset
    input  wire logic [7:0] wdata,     // Write data
    output logic      [7:0] rdata,     // Registered read data
    output logic      [7:0] split_reg, // Queue split register
    output logic      [7:0] ucast_reg, // Unknown unicast register
    output logic      [7:0] mcast_reg  // Unknown multicast register
);

    logic [7:0] split_q, split_d;
    logic [7:0] ucast_q, ucast_d;
    logic [7:0] mcast_q, mcast_d;
    logic [7:0] rdata_q, rdata_d;

    // Writable bits merge in; read-only bits keep their reset value
    always_comb begin
        split_d = split_q;
        ucast_d = ucast_q;
        mcast_d = mcast_q;
        rdata_d = rdata_q;
        if (wr_en) begin
            case (addr)
                `OFS_QUEUE_SPLIT: split_d = (split_q & ~`RO_MASK_QUEUE_SPLIT)
                                            | (wdata & `RO_MASK_QUEUE_SPLIT);
                `OFS_UNK_UCAST:   ucast_d = wdata & `RO_MASK_UNK_UCAST;
                `OFS_UNK_MCAST:   mcast_d = wdata & `RO_MASK_UNK_MCAST;
                default:          ;
            endcase
        end
        if (rd_en) begin
            case (addr)
                `OFS_QUEUE_SPLIT: rdata_d = split_q;
                `OFS_UNK_UCAST:   rdata_d = ucast_q;
                `OFS_UNK_MCAST:   rdata_d = mcast_q;
                default:          rdata_d = 8'h00;
            endcase
        end
    end

    // State registers
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            split_q <= `RST_QUEUE_SPLIT_REG;
            ucast_q <= `RST_UNK_UCAST_REG;
            mcast_q <= `RST_UNK_MCAST_REG;
            rdata_q <= 8'h00;
        end else begin
            split_q <= split_d;
            ucast_q <= ucast_d;
            mcast_q <= mcast_d;
            rdata_q <= rdata_d;
        end
    end

    assign rdata     = rdata_q;
    assign split_reg = split_q;
    assign ucast_reg = ucast_q;
    assign mcast_reg = mcast_q;

endmodule

// ===== unknown_fwd_queue_map.sv
`timescale 1ns/10ps
`include "fwd_queue_params.svh"

// Function
// - Fold 2-bit priority into low/high queue
// - Priority 3 always goes high
// - Priority 1/2 follow split bits 0/1
// - Split 00: only priority 3 high
// - Split 10 (reset): priorities 2,3 high
// - Split applies only in two-queue mode
// - Unicast enable gates unknown unicast handling
// - Decode unicast map to drop/port sets
// - Map bit 0 ignored; 00001 reserved
// - Multicast enable gates unknown multicast handling
// - IP multicast excluded from multicast control
// - Multicast map uses same coding
module unknown_fwd_queue_map
    import fwd_queue_pkg::*;
(
    input  wire logic        ref_clk,      // 200 MHz core clock
    input  wire logic        rst_n,        // Async reset, active low
    input  wire logic        reg_wr,       // Register write strobe
    input  wire logic        reg_rd,       // Register read strobe
    input  wire logic [7:0]  reg_addr,     // Register offset
    input  wire logic [7:0]  reg_wdata,    // Register write data
    output logic      [7:0]  reg_rdata,    // Read data, one cycle after strobe
    output logic             reg_rvalid,   // Read data valid pulse
    input  wire logic        two_queue_mode, // Two-queue operation selected
    input  frame_info_s      frame_in,     // Frame classification
    output fwd_result_s      fwd_out,      // Forwarding decision
    output logic [1:0]       drive_strength // Drive strength field
);

    // ****************************************
    // Register storage
    // ****************************************
    logic [7:0] split_reg;
    logic [7:0] ucast_reg;
    logic [7:0] mcast_reg;
    logic [7:0] rdata_w;

    fwd_ctrl_regs u_regs (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .wr_en     (reg_wr),
        .rd_en     (reg_rd),
        .addr      (reg_addr),
        .wdata     (reg_wdata),
        .rdata     (rdata_w),
        .split_reg (split_reg),
        .ucast_reg (ucast_reg),
        .mcast_reg (mcast_reg)
    );

    // ****************************************
    // Register access sequencing
    // ****************************************
    acc_state_e acc_q, acc_d;
    logic       rvalid_q, rvalid_d;

    // Tracks access kind; read data leaves the memory one cycle later
    always_comb begin
        acc_d    = ACC_IDLE;
        rvalid_d = 1'b0;
        case (acc_q)
            ACC_IDLE, ACC_WRITE, ACC_READ: begin
                if (reg_rd) begin
                    acc_d = ACC_READ;
                end else if (reg_wr) begin
                    acc_d = ACC_WRITE;
                end
                rvalid_d = reg_rd;
            end
            default: acc_d = ACC_IDLE;
        endcase
    end

    // Access state registers
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_q    <= ACC_IDLE;
            rvalid_q <= 1'b0;
        end else begin
            acc_q    <= acc_d;
            rvalid_q <= rvalid_d;
        end
    end

    assign reg_rdata  = rdata_w;
    assign reg_rvalid = rvalid_q;

    // ****************************************
    // Decode helpers
    // ****************************************

    // Shared by both unknown-destination maps; bit 0 matters only for code 00001
    function automatic logic [4:0] decode_map(input logic [4:0] map);
        logic [4:0] r;
        r = 5'h00;                             // {valid, ports[3:0]}
        case (map[4:1])
            `MAP_DROP:   r = (map == `MAP_RESERVED) ? 5'h00 : 5'h10;
            `MAP_PORT1:  r = 5'h11;
            `MAP_PORT2:  r = 5'h12;
            `MAP_PORT12: r = 5'h13;
            `MAP_ALL:    r = 5'h1f;
            default:     r = 5'h00;            // Undefined code: no override
        endcase
        return r;
    endfunction

    // Two-queue fold of the priority result
    function automatic logic fold_prio(input logic [1:0] prio, input logic [1:0] sel);
        logic h;
        case (prio)
            2'h0:    h = 1'b0;
            2'h1:    h = sel[0];
            2'h2:    h = sel[1];
            default: h = 1'b1;
        endcase
        return h;
    endfunction

    // ****************************************
    // Forwarding decision
    // ****************************************
    logic [1:0]  two_queue_split_select;
    logic [4:0]  ucast_dec;
    logic [4:0]  mcast_dec;
    fwd_result_s res_q, res_d;
    logic [1:0]  drive_q, drive_d;
    logic        mode_s1_q, mode_s2_q;

    assign two_queue_split_select = split_reg[`SPLIT_MSB:`SPLIT_LSB];
    assign ucast_dec = decode_map(ucast_reg[`MAP_MSB:0]);
    assign mcast_dec = decode_map(mcast_reg[`MAP_MSB:0]);

    // Split 01 is left to software to avoid; it maps as its bits say
    always_comb begin
        res_d        = '0;
        res_d.valid  = frame_in.valid;
        drive_d      = mcast_reg[`DRIVE_MSB:`DRIVE_LSB];
        if (mode_s2_q) begin
            res_d.high_q = fold_prio(frame_in.prio, two_queue_split_select);
        end else begin
            res_d.high_q = frame_in.prio[1];
        end
        if (frame_in.unk_ucast && ucast_reg[`FWD_EN_BIT] && ucast_dec[4]) begin
            res_d.handled = 1'b1;
            res_d.ports   = ucast_dec[3:0];
            res_d.drop    = (ucast_dec[3:0] == 4'h0);
        end else if (frame_in.unk_mcast && !frame_in.ip_mcast
                     && mcast_reg[`FWD_EN_BIT] && mcast_dec[4]) begin
            res_d.handled = 1'b1;
            res_d.ports   = mcast_dec[3:0];
            res_d.drop    = (mcast_dec[3:0] == 4'h0);
        end
    end

    // Mode pin is quasi-static but still synchronised
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            res_q     <= '0;
            drive_q   <= `RST_DRIVE;
            mode_s1_q <= 1'b0;
            mode_s2_q <= 1'b0;
        end else begin
            res_q     <= res_d;
            drive_q   <= drive_d;
            mode_s1_q <= two_queue_mode;
            mode_s2_q <= mode_s1_q;
        end
    end

    assign fwd_out        = res_q;
    assign drive_strength = drive_q;

endmodule

// ===== fwd_map_assertions.sv
`timescale 1ns/10ps
// ****************************
// Register and decision checks
// ****************************
module fwd_map_chk
    import fwd_queue_pkg::*;
(
    input wire logic       ref_clk,        // Core clock
    input wire logic       rst_n,          // Async reset
    input wire logic       reg_wr,         // Write strobe
    input wire logic       reg_rd,         // Read strobe
    input wire logic [7:0] reg_addr,       // Offset
    input wire logic [7:0] reg_wdata,      // Write data
    input wire logic [7:0] reg_rdata,      // Read data
    input wire logic       reg_rvalid,     // Read valid
    input wire logic       two_queue_mode, // Mode pin
    input frame_info_s     frame_in,       // Frame in
    input fwd_result_s     fwd_out,        // Decision
    input wire logic [1:0] drive_strength  // Drive field
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // Read handshake: answer one cycle on, data held between reads
    property p_rd_ans; reg_rd |=> reg_rvalid; endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
    property p_rd_idle; !reg_rd |=> !reg_rvalid; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("stray read valid");
    property p_rd_hold; !reg_rvalid |-> $stable(reg_rdata); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
    // Queue fold; prio 3 high and prio 0 low in either mode
    property p_valid; frame_in.valid |=> fwd_out.valid; endproperty
    a_valid: assert property (p_valid) else $error("decision missing");
    property p_p3; frame_in.valid && frame_in.prio == 2'h3 |=> fwd_out.high_q; endproperty
    a_p3: assert property (p_p3) else $error("prio 3 not high");
    property p_p0; frame_in.valid && frame_in.prio == 2'h0 |=> !fwd_out.high_q; endproperty
    a_p0: assert property (p_p0) else $error("prio 0 not low");
    // Unknown-destination handling
    property p_none;
        frame_in.valid && !frame_in.unk_ucast && !frame_in.unk_mcast |=> !fwd_out.handled;
    endproperty
    a_none: assert property (p_none) else $error("known frame handled");
    property p_ipmc;
        frame_in.valid && !frame_in.unk_ucast && frame_in.ip_mcast |=> !fwd_out.handled;
    endproperty
    a_ipmc: assert property (p_ipmc) else $error("IP multicast handled");
    property p_drop; fwd_out.handled |-> fwd_out.drop == (fwd_out.ports == 4'h0); endproperty
    a_drop: assert property (p_drop) else $error("drop flag wrong");
    property p_ports;
        fwd_out.handled |-> fwd_out.ports inside {4'h0, 4'h1, 4'h2, 4'h3, 4'hf};
    endproperty
    a_ports: assert property (p_ports) else $error("illegal port set");
    c_read: cover property (reg_rvalid);
    c_drop: cover property (fwd_out.handled && fwd_out.drop);
    c_all: cover property (fwd_out.handled && fwd_out.ports == 4'hf);
endmodule

// ===== unknown_fwd_queue_map_tb_top.sv
`timescale 1ns/10ps
// ****************************
// Self-checking bench
// ****************************
module unknown_fwd_queue_map_tb_top;
    import fwd_queue_pkg::*;
    logic        ref_clk, rst_n, reg_wr, reg_rd, reg_rvalid, two_queue_mode;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, sp, uc, mc, a, d;
    logic [1:0]  drive_strength;
    logic [31:0] r;
    frame_info_s frame_in;
    fwd_result_s fwd_out;
    int          error_cnt = 0, tests_run = 0, cyc = 0, seed;
    unknown_fwd_queue_map u_dut (.ref_clk, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
        .reg_rdata, .reg_rvalid, .two_queue_mode, .frame_in, .fwd_out, .drive_strength);
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    // Hang guard, well above the under 2500 cycles needed
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            complete_run();
        end
    end
    task automatic complete_run;
        $display("Counts: tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // Port set and drop only matter once the frame was handled
    task automatic chk_fwd(input fwd_result_s g, input fwd_result_s e);
        tests_run++;
        if (g.valid !== e.valid || (e.valid && ({g.handled, g.high_q} !== {e.handled, e.high_q}
            || (e.handled && {g.drop, g.ports} !== {e.drop, e.ports})))) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // Map code to {valid, ports}; bit 0 ignored except in 00001
    function automatic logic [4:0] dec(input logic [4:0] m);
        case (m[4:1])
            4'h0: dec = m[0] ? 5'h00 : 5'h10;
            4'h1: dec = 5'h11;
            4'h2: dec = 5'h12;
            4'h3: dec = 5'h13;
            4'hf: dec = 5'h1f;
            default: dec = 5'h00;
        endcase
    endfunction
    function automatic fwd_result_s exp_fwd(input frame_info_s f);
        fwd_result_s e;
        e = '0;
        e.valid = f.valid;
        e.high_q = two_queue_mode ? (f.prio == 2'h3 || (f.prio == 2'h2 && sp[7])
            || (f.prio == 2'h1 && sp[6])) : f.prio[1];
        if (f.unk_ucast && uc[5] && dec(uc[4:0]) > 5'h0f)
            {e.handled, e.ports} = dec(uc[4:0]);
        else if (f.unk_mcast && !f.ip_mcast && mc[5] && dec(mc[4:0]) > 5'h0f)
            {e.handled, e.ports} = dec(mc[4:0]);
        e.drop = e.handled && e.ports == 4'h0;
        return e;
    endfunction
    function automatic logic [7:0] exp_reg(input logic [7:0] x);
        exp_reg = (x == 8'h82) ? sp : (x == 8'h83) ? uc : (x == 8'h84) ? mc : 8'h00;
    endfunction
    // Bus tasks start and end at a falling edge
    task automatic wr(input logic [7:0] x, input logic [7:0] v);
        reg_addr = x;
        reg_wdata = v;
        reg_wr = 1'b1;
        @(negedge ref_clk);
        reg_wr = 1'b0;
        if (x == 8'h82) sp = (v & 8'hc0) | 8'h0c;
        if (x == 8'h83) uc = v & 8'h3f;
        if (x == 8'h84) mc = v;
    endtask
    task automatic rd(input logic [7:0] x);
        reg_addr = x;
        reg_rd = 1'b1;
        @(negedge ref_clk);
        reg_rd = 1'b0;
        chk_byte({7'h0, reg_rvalid}, 8'h01);
        chk_byte(reg_rdata, exp_reg(x));
    endtask
    task automatic frm(input frame_info_s f);
        fwd_result_s e;
        frame_in = f;
        e = exp_fwd(f);
        @(negedge ref_clk);
        chk_fwd(fwd_out, e);
    endtask
    initial begin
        seed = 32'ha391c57f;
        {reg_wr, reg_rd, reg_addr, reg_wdata, rst_n} = '0;
        two_queue_mode = 1'b1;
        frame_in = '0;
        {sp, uc, mc} = {8'h8c, 8'h00, 8'h40};
        repeat (12) @(negedge ref_clk);
        rst_n = 1'b1;
        // Reset values, unmapped offset; strobe held so reads run back-to-back
        reg_rd = 1'b1;
        for (a = 8'h82; a <= 8'h85; a++) begin
            reg_addr = a;
            @(negedge ref_clk);
            chk_byte({7'h0, reg_rvalid}, 8'h01);
            chk_byte(reg_rdata, exp_reg(a));
        end
        reg_rd = 1'b0;
        chk_byte({6'h0, drive_strength}, 8'h01);
        for (a = 8'h82; a <= 8'h85; a++) begin
            wr(a, 8'hff);
            rd(a);
        end
        $display("Test registers done");
        // Every legal split value in both modes; 01 never written
        for (int q = 0; q < 2; q++) begin
            two_queue_mode = q[0];
            for (int i = 0; i < 3; i++) begin
                wr(8'h82, {(i == 0) ? 2'h0 : (i == 1) ? 2'h2 : 2'h3, 6'h00});
                repeat (3) @(negedge ref_clk);
                for (int p = 0; p < 4; p++) frm(frame_info_s'({4'h8, p[1:0]}));
            end
        end
        $display("Test queue fold done");
        // Random config and frames; random maps reach every code
        repeat (300) begin
            r = $random(seed);
            if (r[12:10] == 3'h0) begin
                two_queue_mode = ~two_queue_mode;
                repeat (3) @(negedge ref_clk);
            end
            a = 8'h82 + 8'($unsigned(r[9:8]) % 3);
            d = r[7:0];
            if (a == 8'h82 && d[7:6] == 2'b01) d[7] = 1'b1;
            wr(a, d);
            repeat (4) begin
                r = $random(seed);
                if (r[4]) r[3] = 1'b0;
                frm(frame_info_s'(r[5:0]));
            end
            // Drive copy trails the register by one edge, so look after the frames
            chk_byte({6'h0, drive_strength}, {6'h0, mc[7:6]});
        end
        $display("Test random done");
        complete_run();
    end
endmodule
bind unknown_fwd_queue_map fwd_map_chk u_chk (.ref_clk, .rst_n, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .reg_rdata, .reg_rvalid, .two_queue_mode, .frame_in, .fwd_out, .drive_strength);
